// >>> core/ldoc_config_regs.v
// regulator voltage and enable/discharge configuration registers
// What this block does
// - voltage code decodes linearly, 0 gives 1.3500V, all ones gives 2.9375V.
// - top codes map to top of range, 0x7F gives 2.9375V, no clamping.
// - enable/discharge register lives at offset 0x39 on the register port.
// - system reset clears bits 7..4 and reloads bits 3..0 from fuses.
// - bits 7..4 have no storage; host writes zero, ignores read values.
// - discharge bit zero keeps discharge path off while regulator disabled.
// - discharge bit one with regulator disabled turns on output pull-down.
// - enable-select codes 0..3 follow power sequencer slots 0..3.
// - codes 6 and 7 keep regulator on whenever on/off controller is on.
// - voltage code sits in bits 6..0 of register 0x38, 12.5mV steps.
`timescale 1ns/1ps
`default_nettype none
`include "ldoc_defines.vh"
module ldoc_config_regs (
   // clock and reset
   input wire CLOCK,
   input wire RESET_N,
   input wire SYSTEM_RESET_EVENT,
   // fuse defaults
   input wire [6:0] FUSE_VOLTAGE_CODE,
   input wire [3:0] FUSE_ENDIS,
   // register port
   input wire REG_WR_EN,
   input wire REG_RD_EN,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   // sequencer and on/off controller state
   input wire [3:0] POWER_SEQUENCER_SLOT,
   input wire ONOFF_IS_ON,
   // regulator controls
   output reg REGULATOR_ENABLE,
   output reg DISCHARGE_PULLDOWN_RESISTOR,
   output reg [6:0] REGULATOR_VOLTAGE_CODE,
   output reg [21:0] REGULATOR_TARGET_UV
);
   reg [6:0] vcode_ff;
   reg [3:0] endis_ff;
   reg [6:0] nxt_vcode;
   reg [3:0] nxt_endis;
   reg [7:0] nxt_rdata;
   reg nxt_enable;
   wire [2:0] ensel;
   wire [21:0] target_uv;
   wire wr_v;
   wire wr_e;

   assign wr_v = REG_WR_EN && (REG_ADDR == `LDOC_VOLTAGE_REG_ADDR);
   assign wr_e = REG_WR_EN && (REG_ADDR == `LDOC_ENDIS_REG_ADDR);
   assign ensel = endis_ff[`LDOC_ENSEL_MSB:`LDOC_ENSEL_LSB];

   always @* begin
      nxt_vcode = vcode_ff;
      nxt_endis = endis_ff;
      if (SYSTEM_RESET_EVENT) begin
         // fuse values are sampled here, never under the async reset
         nxt_vcode = FUSE_VOLTAGE_CODE;
         nxt_endis = FUSE_ENDIS;
      end else begin
         if (wr_v)
            nxt_vcode = REG_WDATA[6:0];
         if (wr_e)
            nxt_endis = REG_WDATA[3:0];
      end
   end

   always @* begin
      nxt_rdata = 8'h00;
      if (REG_RD_EN) begin
         case (REG_ADDR)
            `LDOC_VOLTAGE_REG_ADDR: nxt_rdata = {1'b0, vcode_ff};
            `LDOC_ENDIS_REG_ADDR: nxt_rdata = {4'h0, endis_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always @* begin
      case (ensel)
         3'h0, 3'h1, 3'h2, 3'h3: nxt_enable = POWER_SEQUENCER_SLOT[ensel[1:0]];
         `LDOC_ENSEL_ALWAYS_ON_A, `LDOC_ENSEL_ALWAYS_ON_B: nxt_enable = ONOFF_IS_ON;
         default: nxt_enable = 1'b0;
      endcase
   end

   ldoc_voltage_decode u_decode (
      .code(vcode_ff),
      .target_uv(target_uv)
   );

   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         vcode_ff <= 7'h00;
         endis_ff <= 4'h0;
         REG_RDATA <= 8'h00;
         REGULATOR_ENABLE <= 1'b0;
         DISCHARGE_PULLDOWN_RESISTOR <= 1'b0;
         REGULATOR_VOLTAGE_CODE <= 7'h00;
         REGULATOR_TARGET_UV <= 22'h000000;
      end else begin
         vcode_ff <= nxt_vcode;
         endis_ff <= nxt_endis;
         if (REG_RD_EN)
            REG_RDATA <= nxt_rdata;
         REGULATOR_ENABLE <= nxt_enable;
         // pull-down only while off and enabled by the discharge bit
         DISCHARGE_PULLDOWN_RESISTOR <= !nxt_enable && endis_ff[`LDOC_ADE_BIT];
         REGULATOR_VOLTAGE_CODE <= vcode_ff;
         REGULATOR_TARGET_UV <= target_uv;
      end
   end
endmodule
`default_nettype wire

// >>> core/ldoc_defines.vh
// constants for the regulator configuration register block
`ifndef LDOC_DEFINES_VH
`define LDOC_DEFINES_VH
`define LDOC_VOLTAGE_REG_ADDR 8'h38
`define LDOC_ENDIS_REG_ADDR 8'h39
`define LDOC_ADE_BIT 3
`define LDOC_ENSEL_MSB 2
`define LDOC_ENSEL_LSB 0
`define LDOC_ENDIS_STORED_MASK 8'h0F
`define LDOC_VCODE_MASK 8'h7F
`define LDOC_VMIN_UV 22'h149970
`define LDOC_VSTEP_UV 22'h0030D4
`define LDOC_VMAX_UV 22'h2CD29C
`define LDOC_ENSEL_ALWAYS_ON_A 3'h6
`define LDOC_ENSEL_ALWAYS_ON_B 3'h7
`endif

// >>> core/ldoc_voltage_decode.v
// linear decode of the 7-bit regulator voltage code into microvolts
`timescale 1ns/1ps
`default_nettype none
`include "ldoc_defines.vh"
module ldoc_voltage_decode (
   // code in
   input wire [6:0] code,
   // target out
   output wire [21:0] target_uv
);
   wire [21:0] base_uv;
   wire [21:0] step_uv;
   assign base_uv = `LDOC_VMIN_UV;
   assign step_uv = `LDOC_VSTEP_UV;
   // no clamp: 0x7F lands exactly on the top of range
   assign target_uv = base_uv + step_uv * {15'h0000, code};
endmodule
`default_nettype wire

// >>> tb/ldoc_config_regs_props.sv
// port assertions for the regulator configuration registers
`timescale 1ns/1ps
`default_nettype none
module ldoc_config_regs_props (
   input wire CLOCK, RESET_N, SYSTEM_RESET_EVENT, REG_WR_EN, REG_RD_EN,
   input wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
   input wire [6:0] FUSE_VOLTAGE_CODE, REGULATOR_VOLTAGE_CODE,
   input wire REGULATOR_ENABLE, DISCHARGE_PULLDOWN_RESISTOR,
   input wire [21:0] REGULATOR_TARGET_UV
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   wire wr38 = REG_WR_EN && REG_ADDR == 8'h38;
   a_target_linear: assert property ($stable(REGULATOR_VOLTAGE_CODE)[*3] |->
      REGULATOR_TARGET_UV == 22'd1350000 + 22'd12500 * REGULATOR_VOLTAGE_CODE) else $error("uv");
   a_pull_excl: assert property (DISCHARGE_PULLDOWN_RESISTOR |-> !REGULATOR_ENABLE) else $error("pd");
   a_code_write: assert property (wr38 && !SYSTEM_RESET_EVENT ##1 !REG_WR_EN && !SYSTEM_RESET_EVENT
      |=> REGULATOR_VOLTAGE_CODE == $past(REG_WDATA[6:0], 2)) else $error("code");
   a_fuse_load: assert property (SYSTEM_RESET_EVENT ##1 !SYSTEM_RESET_EVENT && !REG_WR_EN
      |=> REGULATOR_VOLTAGE_CODE == $past(FUSE_VOLTAGE_CODE, 2)) else $error("fuse");
   a_rdata_hold: assert property (!REG_RD_EN |=> $stable(REG_RDATA)) else $error("hold");
   a_unmapped_zero: assert property (REG_RD_EN && REG_ADDR > 8'h39 |=> REG_RDATA == 8'h00) else $error("um");
   a_blank_bits: assert property (REG_RD_EN && REG_ADDR == 8'h39 |=> REG_RDATA[7:4] == 4'h0) else $error("bl");
   a_code_msb: assert property (REG_RD_EN && REG_ADDR == 8'h38 |=> !REG_RDATA[7]) else $error("msb");
   c_on: cover property (REGULATOR_ENABLE);
   c_pull: cover property (DISCHARGE_PULLDOWN_RESISTOR);
   c_wr: cover property (wr38);
endmodule
bind ldoc_config_regs ldoc_config_regs_props ldoc_config_regs_props_i (.*);
`default_nettype wire

// >>> tb/ldoc_host_model.sv
// host side of the register port, one access per call
`timescale 1ns/1ps
`default_nettype none
module ldoc_host_model (
   input wire logic CLOCK,
   output logic REG_WR_EN, REG_RD_EN,
   output logic [7:0] REG_ADDR, REG_WDATA
);
   initial {REG_WR_EN, REG_RD_EN, REG_ADDR, REG_WDATA} = 18'h0;
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge CLOCK) #1 {REG_WR_EN, REG_RD_EN, REG_ADDR, REG_WDATA} = {w, !w, a, d};
      // released bus shows inverted values so stale data cannot pass
      @(posedge CLOCK) #1 {REG_WR_EN, REG_RD_EN, REG_ADDR, REG_WDATA} = {2'b00, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// >>> tb/test_ldoc_config_regs.sv
// self-checking bench for the regulator configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_ldoc_config_regs;
   logic CLOCK = 0, RESET_N = 0, SYSTEM_RESET_EVENT = 0, ONOFF_IS_ON = 0, REG_WR_EN, REG_RD_EN;
   logic [3:0] POWER_SEQUENCER_SLOT = 4'h0;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   logic REGULATOR_ENABLE, DISCHARGE_PULLDOWN_RESISTOR;
   logic [6:0] REGULATOR_VOLTAGE_CODE;
   logic [21:0] REGULATOR_TARGET_UV;
   int fail_count = 0, checks_done = 0;
   always #5 CLOCK = ~CLOCK;
   ldoc_config_regs ldoc_config_regs_i (.FUSE_VOLTAGE_CODE(7'h5F), .FUSE_ENDIS(4'hE), .*);
   ldoc_host_model ldoc_host_model_i (.*);
   task chk(input logic [21:0] g, e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000 fail_count++;
      summarize;
   end
   initial begin
      repeat (3) @(posedge CLOCK);
      #1 RESET_N = 1;
      @(posedge CLOCK) #1 SYSTEM_RESET_EVENT = 1;
      @(posedge CLOCK) #1 SYSTEM_RESET_EVENT = 0;
      ldoc_host_model_i.acc(0, 8'h39, 8'h00);
      chk(REG_RDATA, 8'h0E);
      chk(DISCHARGE_PULLDOWN_RESISTOR, 1);
      ONOFF_IS_ON = 1;
      POWER_SEQUENCER_SLOT = 4'h5;
      ldoc_host_model_i.acc(0, 8'h38, 8'h00);
      chk(REG_RDATA, 8'h5F);
      chk(REGULATOR_ENABLE, 1);
      chk(REGULATOR_TARGET_UV, 22'd2537500);
      for (int c = 0; c < 8; c++) begin
         ldoc_host_model_i.acc(1, 8'h39, c[7:0]);
         ldoc_host_model_i.acc(0, 8'h39, 8'h00);
         chk(REG_RDATA, c[7:0]);
         chk(REGULATOR_ENABLE, c < 4 ? POWER_SEQUENCER_SLOT[c] : c > 5);
         chk(DISCHARGE_PULLDOWN_RESISTOR, 0);
      end
      ldoc_host_model_i.acc(1, 8'h38, 8'h7F);
      ldoc_host_model_i.acc(0, 8'h38, 8'h00);
      chk(REG_RDATA, 8'h7F);
      ldoc_host_model_i.acc(0, 8'h40, 8'h00);
      chk(REG_RDATA, 8'h00);
      chk(REGULATOR_TARGET_UV, 22'd2937500);
      chk(REGULATOR_VOLTAGE_CODE, 7'h7F);
      summarize;
   end
endmodule
`default_nettype wire
